// File: bench/access_channel_arbiter_assertions.sv
/*
 * Checker of the access channel arbiter, bound to its ports.
 * Assumes one clock domain and the arbiter package compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module access_channel_arbiter_checker (
	input wire logic ref_clk, // Clock
	input wire logic rst_n, // Reset, low active
	input wire logic parWrite, // Write strobe
	input wire logic [15:0] parAddr, // Address
	input wire logic [15:0] parWdata, // Write data
	input wire logic parAck, // Done
	input wire logic parErr, // Refused
	input wire logic fbCmdValid, // Fieldbus strobe
	input wire logic swCmdValid, // Software strobe
	input wire logic dinCmdValid, // Input strobe
	input wire logic swExclusiveSwitch, // Switch
	input wire logic modeActive, // Mode running
	input wire logic powerStageEnabled, // Power stage
	input wire access_arbiter_pkg::safety_t safetyPins, // Pins
	input wire logic cmdValid, // Granted
	input wire access_arbiter_pkg::src_t cmdSrc, // Source
	input wire access_arbiter_pkg::cmd_t cmdOut, // Command
	input wire logic cmdRefused, // Refused
	input wire access_arbiter_pkg::owner_t exclusiveOwner, // Owner
	input wire logic localMode, // Local mode
	input wire access_arbiter_pkg::safety_t safetyOut // Safety levels
);
	// ----------
	// Decodes
	// ----------
	wire logic lockWr = parWrite &&
		parAddr == access_arbiter_pkg::ADDR_OTHER_CHANNEL_LOCK;
	wire logic lockSet = lockWr && parWdata == access_arbiter_pkg::LOCK_BLOCK;
	wire logic lockClr = lockWr && parWdata == access_arbiter_pkg::LOCK_ALLOW;
	wire logic selWr = parWrite &&
		parAddr == access_arbiter_pkg::ADDR_CONTROL_SOURCE_SELECT;
	wire logic swOwn = exclusiveOwner == access_arbiter_pkg::OWN_SOFTWARE;
	wire logic fbOwn = exclusiveOwner == access_arbiter_pkg::OWN_FIELDBUS;
	wire logic noOwn = exclusiveOwner == access_arbiter_pkg::OWN_NONE;
	wire logic stateCmd = cmdValid &&
		cmdOut.kind != access_arbiter_pkg::KIND_OTHER;
	wire logic onlyDin = dinCmdValid && !fbCmdValid && !swCmdValid;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// ----------
	// Properties
	// ----------
	a_single_owner: assert property ($onehot(exclusiveOwner))
		else $error("owner not one-hot");
	a_lock_waits: assert property (lockSet && modeActive
		|=> parErr && !parAck) else $error("lock taken in mode");
	a_lock_takes: assert property (lockSet && !modeActive
		&& !swOwn |=> parAck && fbOwn) else $error("lock not applied");
	a_lock_frees: assert property (lockClr && fbOwn |=> noOwn)
		else $error("lock not released");
	a_switch_takes: assert property (noOwn && swExclusiveSwitch
		&& !parWrite |=> swOwn) else $error("switch ignored");
	a_mode_frozen: assert property (rst_n && $past(rst_n)
		&& $past(rst_n, 2) |-> $stable(localMode))
		else $error("control mode changed in run");
	a_sel_locked: assert property (selWr && powerStageEnabled
		|=> parErr) else $error("mode write taken when enabled");
	a_din_local: assert property (stateCmd
		&& cmdSrc == access_arbiter_pkg::SRC_INPUTS |-> localMode)
		else $error("input command outside local mode");
	a_fb_remote: assert property (stateCmd
		&& cmdSrc == access_arbiter_pkg::SRC_FIELDBUS |-> !localMode)
		else $error("fieldbus command in local mode");
	a_local_modes: assert property (cmdValid && localMode
		&& cmdOut.kind == access_arbiter_pkg::KIND_MODE_START
		|-> cmdOut.opMode inside {access_arbiter_pkg::OP_JOG,
		access_arbiter_pkg::OP_MOTION_SEQUENCE})
		else $error("mode not offered locally");
	a_cmd_answer: assert property (onlyDin
		|=> cmdValid || cmdRefused) else $error("command unanswered");
	a_safety_follow: assert property ($stable(safetyPins)[*8]
		|-> safetyOut == safetyPins) else $error("safety level lost");
	c_lock_taken: cover property (lockSet ##1 parAck);
	c_local_start: cover property (cmdValid && localMode);
	c_sw_owner: cover property (swOwn);
endmodule
bind access_channel_arbiter access_channel_arbiter_checker chk_u (
	.ref_clk, .rst_n, .parWrite, .parAddr, .parWdata, .parAck, .parErr,
	.fbCmdValid, .swCmdValid, .dinCmdValid, .swExclusiveSwitch,
	.modeActive, .powerStageEnabled, .safetyPins, .cmdValid, .cmdSrc,
	.cmdOut, .cmdRefused, .exclusiveOwner, .localMode, .safetyOut
);
`default_nettype wire

// File: bench/access_channel_arbiter_tb_top.sv
/*
 * Self-checking bench of the access channel arbiter.
 * Assumes package, design, checker and fieldbus model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module access_channel_arbiter_tb_top;
	// ----------
	// Signals
	// ----------
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic parWrite, parRead, parAck, parErr, cmdValid, cmdRefused;
	logic fbCmdValid, localMode;
	logic swCmdValid = 1'h0;
	logic dinCmdValid = 1'h0;
	logic swExclusiveSwitch = 1'h0;
	logic modeActive = 1'h0;
	logic powerStageEnabled = 1'h0;
	logic [15:0] parAddr, parWdata, parRdata;
	access_arbiter_pkg::cmd_t fbCmd, cmdOut;
	access_arbiter_pkg::cmd_t swCmd = '0;
	access_arbiter_pkg::cmd_t dinCmd = '0;
	access_arbiter_pkg::safety_t safetyPins = '0;
	access_arbiter_pkg::safety_t safetyOut;
	access_arbiter_pkg::src_t cmdSrc;
	access_arbiter_pkg::owner_t exclusiveOwner;
	logic [17:0] pq[$];
	logic [23:0] cq[$];
	logic [17:0] pe;
	logic [23:0] ce;
	int n_fail = 0;
	int tests_run = 0;
	int seed;
	always #10 ref_clk = ~ref_clk;
	access_channel_arbiter dut_u (.ref_clk, .rst_n, .parWrite, .parRead,
		.parAddr, .parWdata, .parAck, .parErr, .parRdata, .fbCmdValid,
		.fbCmd, .swCmdValid, .swCmd, .dinCmdValid, .dinCmd,
		.swExclusiveSwitch, .modeActive, .powerStageEnabled, .safetyPins,
		.cmdValid, .cmdSrc, .cmdOut, .cmdRefused, .exclusiveOwner,
		.localMode, .safetyOut);
	fb_master_model fbm_u (.ref_clk, .parAck, .parErr, .parWrite,
		.parRead, .parAddr, .parWdata, .fbCmdValid, .fbCmd);
	// ----------
	// Tasks
	// ----------
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic par(input logic wr, input logic [15:0] a, d,
		input logic err, input logic [15:0] rd);
		pq.push_back({!wr, err, rd});
		fbm_u.acc(wr, a, d);
	endtask
	// Channel code follows the source encoding of the grant
	task automatic cm(input logic [1:0] ch, input logic [4:0] km,
		input logic ok);
		logic [20:0] c;
		c = {km, 16'($urandom)};
		cq.push_back({!ok, ch, c});
		if (ch == 2'h0) begin
			fbm_u.cmd(c);
		end else begin
			@(negedge ref_clk);
			swCmd = c;
			dinCmd = c;
			swCmdValid = ch == 2'h1;
			dinCmdValid = ch == 2'h2;
			@(negedge ref_clk);
			swCmdValid = 1'h0;
			dinCmdValid = 1'h0;
			swCmd = ~c;
			dinCmd = ~c;
		end
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ----------
	// Result watcher
	// ----------
	always @(negedge ref_clk) begin
		if (parAck | parErr) begin
			chk(pq.size() != 0, 1'h1);
			pe = pq.pop_front();
			chk({parAck, parErr}, {!pe[16], pe[16]});
			if (pe[17])
				chk(parRdata, pe[15:0]);
		end
		if (cmdValid | cmdRefused) begin
			chk(cq.size() != 0, 1'h1);
			ce = cq.pop_front();
			chk({cmdValid, cmdRefused}, {!ce[23], ce[23]});
			if (!ce[23])
				chk({cmdSrc, cmdOut}, ce[22:0]);
		end
	end
	initial begin
		#100000;
		n_fail++;
		stop_test;
	end
	// ----------
	// Scenarios
	// ----------
	initial begin
		seed = $urandom(32'h8B4EEFA0);
		repeat (10) @(negedge ref_clk);
		rst_n = 1'h1;
		@(negedge ref_clk);
		chk(exclusiveOwner, access_arbiter_pkg::OWN_NONE);
		chk(localMode, 1'h0);
		par(1'h0, 16'h0502, 16'h0000, 1'h0, 16'h0002);
		par(1'h1, 16'h011C, 16'h0002, 1'h1, 16'h0000);
		par(1'h1, 16'h0123, 16'h0000, 1'h1, 16'h0000);
		modeActive = 1'h1;
		par(1'h1, 16'h011C, 16'h0001, 1'h1, 16'h0000);
		par(1'h0, 16'h011C, 16'h0000, 1'h0, 16'h0000);
		modeActive = 1'h0;
		par(1'h1, 16'h011C, 16'h0001, 1'h0, 16'h0000);
		chk(exclusiveOwner, access_arbiter_pkg::OWN_FIELDBUS);
		safetyPins = 8'($urandom);
		swExclusiveSwitch = 1'h1;
		cm(2'h1, 5'h00, 1'h0);
		cm(2'h2, 5'h00, 1'h0);
		cm(2'h0, 5'h10, 1'h1);
		chk(safetyOut, safetyPins);
		chk(exclusiveOwner, access_arbiter_pkg::OWN_FIELDBUS);
		par(1'h1, 16'h011C, 16'h0000, 1'h0, 16'h0000);
		@(negedge ref_clk);
		chk(exclusiveOwner, access_arbiter_pkg::OWN_SOFTWARE);
		par(1'h1, 16'h011C, 16'h0001, 1'h1, 16'h0000);
		cm(2'h0, 5'h00, 1'h0);
		cm(2'h1, 5'h0B, 1'h1);
		swExclusiveSwitch = 1'h0;
		for (int i = 0; i < 7; i++)
			cm(2'h0, {2'h2, 3'(i)}, 1'h1);
		cm(2'h2, 5'h10, 1'h0);
		cm(2'h2, 5'h00, 1'h1);
		powerStageEnabled = 1'h1;
		par(1'h1, 16'h0502, 16'h0001, 1'h1, 16'h0000);
		powerStageEnabled = 1'h0;
		par(1'h1, 16'h0502, 16'h0003, 1'h1, 16'h0000);
		par(1'h1, 16'h0502, 16'h0001, 1'h0, 16'h0000);
		chk(localMode, 1'h0);
		par(1'h0, 16'h0502, 16'h0000, 1'h0, 16'h0001);
		// Second reset stands in for the next power-on
		rst_n = 1'h0;
		@(negedge ref_clk);
		rst_n = 1'h1;
		repeat (2) @(negedge ref_clk);
		chk(localMode, 1'h1);
		for (int i = 0; i < 7; i++)
			cm(2'h2, {2'h2, 3'(i)}, i == 0 || i == 6);
		cm(2'h0, 5'h08, 1'h0);
		cm(2'h0, 5'h00, 1'h1);
		// Every noted request must have had its answer
		chk(pq.size() + cq.size(), 0);
		stop_test;
	end
endmodule
`default_nettype wire

// File: bench/fb_master_model.sv
/*
 * Fieldbus master model: parameter accesses and commands as tasks.
 * Assumes accesses are answered within a few cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module fb_master_model (
	input wire logic ref_clk, // Clock
	input wire logic parAck, // Done
	input wire logic parErr, // Refused
	output logic parWrite, // Write strobe
	output logic parRead, // Read strobe
	output logic [15:0] parAddr, // Address
	output logic [15:0] parWdata, // Write data
	output logic fbCmdValid, // Command strobe
	output access_arbiter_pkg::cmd_t fbCmd // Command
);
	initial begin
		parWrite = 1'h0;
		parRead = 1'h0;
		parAddr = 16'h0000;
		parWdata = 16'h0000;
		fbCmdValid = 1'h0;
		fbCmd = '0;
	end
	// Lock and mode writes travel this path
	task automatic acc(input logic wr, input logic [15:0] a, d);
		int k;
		@(negedge ref_clk);
		parAddr = a;
		parWdata = d;
		parWrite = wr;
		parRead = !wr;
		@(negedge ref_clk);
		parWrite = 1'h0;
		parRead = 1'h0;
		// Released bus shows inverted data, not a stale match
		parAddr = ~a;
		parWdata = ~d;
		k = 0;
		while (!(parAck | parErr) && k < 4) begin
			@(negedge ref_clk);
			k++;
		end
		@(negedge ref_clk);
	endtask
	// Fieldbus commands
	task automatic cmd(input access_arbiter_pkg::cmd_t c);
		@(negedge ref_clk);
		fbCmd = c;
		fbCmdValid = 1'h1;
		@(negedge ref_clk);
		fbCmdValid = 1'h0;
		fbCmd = ~c;
	endtask
endmodule
`default_nettype wire

// File: src/access_arbiter_pkg.sv
/*
 * Shared constants and types of the access channel arbiter:
 * parameter addresses, codes of the control mode and operating modes,
 * and the command carrier.
 * Assumes a 16-bit parameter access path with the fixed addresses below.
 */
package access_arbiter_pkg;

	// ------------------------------------------------------------
	// Parameter addresses and values
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_OTHER_CHANNEL_LOCK = 16'h011C;
	localparam logic [15:0] ADDR_CONTROL_SOURCE_SELECT = 16'h0502;
	localparam logic [15:0] LOCK_ALLOW = 16'h0000;
	localparam logic [15:0] LOCK_BLOCK = 16'h0001;
	localparam logic [15:0] SEL_LOCAL = 16'h0001;
	localparam logic [15:0] SEL_FIELDBUS = 16'h0002;
	localparam logic [15:0] SEL_RESET = 16'h0002;
	localparam logic [15:0] DATA_ZERO = 16'h0000;

	// ------------------------------------------------------------
	// Synchroniser reset level and safety input count
	// ------------------------------------------------------------
	localparam int SAFE_WIDTH = 8;
	localparam logic [SAFE_WIDTH-1:0] SAFE_RESET = 8'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_JOG = 3'h0,
		OP_PROFILE_TORQUE = 3'h1,
		OP_PROFILE_VELOCITY = 3'h2,
		OP_PROFILE_POSITION = 3'h3,
		OP_INTERPOLATED_POSITION = 3'h4,
		OP_HOMING = 3'h5,
		OP_MOTION_SEQUENCE = 3'h6,
		OP_NONE = 3'h7
	} op_mode_t;

	typedef enum logic [1:0] {
		KIND_OTHER = 2'h0,
		KIND_STATE_CHANGE = 2'h1,
		KIND_MODE_START = 2'h2
	} cmd_kind_t;

	typedef struct packed {
		cmd_kind_t kind;
		op_mode_t opMode;
		logic [15:0] arg;
	} cmd_t;

	typedef enum logic [1:0] {
		SRC_FIELDBUS = 2'h0,
		SRC_SOFTWARE = 2'h1,
		SRC_INPUTS = 2'h2,
		SRC_NONE = 2'h3
	} src_t;

	typedef enum logic [2:0] {
		OWN_NONE = 3'b001,
		OWN_FIELDBUS = 3'b010,
		OWN_SOFTWARE = 3'b100
	} owner_t;

	typedef struct packed {
		logic halt;
		logic faultReset;
		logic enable;
		logic positive_limit_switch;
		logic negative_limit_switch;
		logic referenceSwitch;
		logic safe_torque_off_a;
		logic safe_torque_off_b;
	} safety_t;

endpackage

// File: src/access_channel_arbiter.sv
/*
 * Access channel arbiter: picks which of fieldbus, commissioning
 * software and digital inputs may command the drive, handles the
 * exclusive access lock and the local/fieldbus control mode.
 * Assumes parameter requests, commands and drive status come from
 * logic on ref_clk; safety inputs come from pins.
 */
// Notes on behaviour
// - Accept commands from fieldbus, software, inputs.
// - At most one channel holds exclusive access.
// - Lock 1 gives fieldbus exclusivity; 0 releases.
// - Software switch on makes software sole controller.
// - Power-on starts without any exclusive access.
// - Safety and limit inputs always stay effective.
// - Lock applied only with no operating mode active.
// - Lock value acts immediately once accepted.
// - Local mode: state/mode commands from inputs, or from software while it holds exclusive access.
// - Fieldbus mode: state/mode commands from fieldbus, or from software while it holds exclusive access.
// - Control mode code 1 local, 2 fieldbus.
// - Control mode change only with power stage off.
// - New control mode active after next power-on.
// - Local mode offers only jog, motion sequence.
`timescale 1ns/1ps
`default_nettype none
module access_channel_arbiter (
	input wire logic ref_clk, // 50 MHz system clock
	input wire logic rst_n, // Power-on reset, low active
	input wire logic parWrite, // Fieldbus parameter write strobe
	input wire logic parRead, // Fieldbus parameter read strobe
	input wire logic [15:0] parAddr, // Parameter address
	input wire logic [15:0] parWdata, // Parameter write data
	output logic parAck, // Parameter access done pulse
	output logic parErr, // Parameter access refused pulse
	output logic [15:0] parRdata, // Parameter read data
	input wire logic fbCmdValid, // Fieldbus command strobe
	input wire access_arbiter_pkg::cmd_t fbCmd, // Fieldbus command
	input wire logic swCmdValid, // Software command strobe
	input wire access_arbiter_pkg::cmd_t swCmd, // Software command
	input wire logic dinCmdValid, // Digital input command strobe
	input wire access_arbiter_pkg::cmd_t dinCmd, // Digital input command
	input wire logic swExclusiveSwitch, // Software exclusive switch on
	input wire logic modeActive, // An operating mode is running
	input wire logic powerStageEnabled, // Power stage is enabled
	input wire access_arbiter_pkg::safety_t safetyPins, // Safety pins
	output logic cmdValid, // Granted command pulse
	output access_arbiter_pkg::src_t cmdSrc, // Source of granted command
	output access_arbiter_pkg::cmd_t cmdOut, // Granted command
	output logic cmdRefused, // A command strobe was refused
	output access_arbiter_pkg::owner_t exclusiveOwner, // Exclusive owner
	output logic localMode, // Local control mode active
	output access_arbiter_pkg::safety_t safetyOut // Safety levels
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Operating mode offered in the active control mode
	function automatic logic modeAllowed(
		input access_arbiter_pkg::op_mode_t m,
		input logic isLocal
	);
		logic ok;
		ok = 1'b0;
		if (isLocal) begin
			ok = (m == access_arbiter_pkg::OP_JOG) ||
				(m == access_arbiter_pkg::OP_MOTION_SEQUENCE);
		end else begin
			ok = (m != access_arbiter_pkg::OP_NONE);
		end
		return ok;
	endfunction

	// State changes and mode starts are reserved to one channel
	function automatic logic isControl(input access_arbiter_pkg::cmd_t c);
		logic r;
		r = (c.kind == access_arbiter_pkg::KIND_STATE_CHANGE) ||
			(c.kind == access_arbiter_pkg::KIND_MODE_START);
		return r;
	endfunction

	function automatic logic cmdUsable(
		input access_arbiter_pkg::cmd_t c,
		input logic isLocal
	);
		logic r;
		r = (c.kind != access_arbiter_pkg::KIND_MODE_START) ||
			modeAllowed(c.opMode, isLocal);
		return r;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	access_arbiter_pkg::owner_t owner_reg;
	access_arbiter_pkg::owner_t owner_next;
	logic [15:0] lock_reg;
	logic [15:0] lock_next;
	// Power-on value only; rst_n leaves the stored choice alone
	logic [15:0] storedSel_reg = access_arbiter_pkg::SEL_RESET;
	logic [15:0] storedSel_next;
	logic localActive_reg;
	logic activeLoaded_reg;

	// ------------------------------------------------------------
	// Parameter access decode
	// ------------------------------------------------------------
	wire logic hitLock =
		(parAddr == access_arbiter_pkg::ADDR_OTHER_CHANNEL_LOCK);
	wire logic hitSel =
		(parAddr == access_arbiter_pkg::ADDR_CONTROL_SOURCE_SELECT);
	wire logic lockValueOk = (parWdata == access_arbiter_pkg::LOCK_ALLOW) ||
		(parWdata == access_arbiter_pkg::LOCK_BLOCK);
	wire logic lockOn = (parWdata == access_arbiter_pkg::LOCK_BLOCK);
	wire logic selValueOk = (parWdata == access_arbiter_pkg::SEL_LOCAL) ||
		(parWdata == access_arbiter_pkg::SEL_FIELDBUS);
	// Locking is refused while a mode runs; software exclusivity blocks it
	wire logic lockWriteOk = parWrite && hitLock && lockValueOk &&
		!(lockOn && (modeActive ||
		owner_reg == access_arbiter_pkg::OWN_SOFTWARE));
	wire logic selWriteOk = parWrite && hitSel && selValueOk &&
		!powerStageEnabled;
	wire logic parAny = parWrite || parRead;
	wire logic readOk = parRead && !parWrite && (hitLock || hitSel);
	wire logic parFail = parAny && !(lockWriteOk || selWriteOk || readOk);
	wire logic [15:0] readData = hitLock ? lock_reg :
		(hitSel ? storedSel_reg : access_arbiter_pkg::DATA_ZERO);

	// Refused writes simply keep the old value
	assign lock_next = lockWriteOk ? parWdata : lock_reg;
	assign storedSel_next = selWriteOk ? parWdata : storedSel_reg;

	// ------------------------------------------------------------
	// Exclusive owner
	// ------------------------------------------------------------
	// Next lock value steers the owner in the same cycle it is stored
	wire logic lockSet = (lock_next == access_arbiter_pkg::LOCK_BLOCK);

	always_comb begin
		owner_next = owner_reg;
		case (owner_reg)
			access_arbiter_pkg::OWN_NONE: begin
				if (lockSet) begin
					owner_next = access_arbiter_pkg::OWN_FIELDBUS;
				end else if (swExclusiveSwitch) begin
					owner_next = access_arbiter_pkg::OWN_SOFTWARE;
				end
			end
			access_arbiter_pkg::OWN_FIELDBUS: begin
				if (!lockSet) begin
					owner_next = access_arbiter_pkg::OWN_NONE;
				end
			end
			access_arbiter_pkg::OWN_SOFTWARE: begin
				if (!swExclusiveSwitch) begin
					owner_next = access_arbiter_pkg::OWN_NONE;
				end
			end
			default: begin
				owner_next = access_arbiter_pkg::OWN_NONE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Command arbitration
	// ------------------------------------------------------------
	wire logic ownFb = (owner_reg == access_arbiter_pkg::OWN_FIELDBUS);
	wire logic ownSw = (owner_reg == access_arbiter_pkg::OWN_SOFTWARE);
	wire logic ownNone = (owner_reg == access_arbiter_pkg::OWN_NONE);
	wire logic isLocal = localActive_reg;

	// Each channel must own the bus or be free to act in this mode
	wire logic fbEligible = fbCmdValid && !ownSw &&
		(!isControl(fbCmd) || !isLocal) &&
		cmdUsable(fbCmd, isLocal);
	wire logic swEligible = swCmdValid && !ownFb &&
		(ownSw || !isControl(swCmd)) &&
		cmdUsable(swCmd, isLocal);
	wire logic dinEligible = dinCmdValid && ownNone &&
		(!isControl(dinCmd) || isLocal) &&
		cmdUsable(dinCmd, isLocal);

	// Fixed priority: only one command leaves per cycle
	wire logic grantFb = fbEligible;
	wire logic grantSw = swEligible && !grantFb;
	wire logic grantDin = dinEligible && !grantFb && !grantSw;
	wire logic anyGrant = grantFb || grantSw || grantDin;
	wire logic anyReq = fbCmdValid || swCmdValid || dinCmdValid;
	wire access_arbiter_pkg::cmd_t grantCmd = grantFb ? fbCmd :
		(grantSw ? swCmd : dinCmd);
	wire access_arbiter_pkg::src_t grantSrc = grantFb ?
		access_arbiter_pkg::SRC_FIELDBUS : (grantSw ?
		access_arbiter_pkg::SRC_SOFTWARE : (grantDin ?
		access_arbiter_pkg::SRC_INPUTS : access_arbiter_pkg::SRC_NONE));
	// Losing strobes count as refused too
	wire logic refusedAny = (anyReq && !anyGrant) ||
		(grantFb && (swCmdValid || dinCmdValid)) ||
		(grantSw && dinCmdValid);

	// ------------------------------------------------------------
	// Safety inputs
	// ------------------------------------------------------------
	// These bypass arbitration entirely, so exclusivity never masks them
	logic [access_arbiter_pkg::SAFE_WIDTH-1:0] safetySync;

	input_sync #(
		.WIDTH(access_arbiter_pkg::SAFE_WIDTH),
		.INIT(access_arbiter_pkg::SAFE_RESET)
	) u_safety_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pinIn(safetyPins),
		.syncOut(safetySync)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			safetyOut <= access_arbiter_pkg::SAFE_RESET;
		end else begin
			safetyOut <= safetySync;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			owner_reg <= access_arbiter_pkg::OWN_NONE;
			lock_reg <= access_arbiter_pkg::LOCK_ALLOW;
		end else begin
			owner_reg <= owner_next;
			lock_reg <= lock_next;
		end
	end

	// Kept across rst_n, or a new control mode could never take over
	always_ff @(posedge ref_clk) begin
		storedSel_reg <= storedSel_next;
	end

	// ------------------------------------------------------------
	// Active control mode
	// ------------------------------------------------------------
	// Active mode caught once after reset release, then frozen
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			activeLoaded_reg <= 1'b0;
			localActive_reg <= 1'b0;
		end else if (!activeLoaded_reg) begin
			activeLoaded_reg <= 1'b1;
			localActive_reg <= (storedSel_reg ==
				access_arbiter_pkg::SEL_LOCAL);
		end
	end

	// ------------------------------------------------------------
	// Parameter answers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			parAck <= 1'b0;
			parErr <= 1'b0;
			parRdata <= access_arbiter_pkg::DATA_ZERO;
		end else begin
			parAck <= parAny && !parFail;
			parErr <= parFail;
			parRdata <= readOk ? readData : parRdata;
		end
	end

	// ------------------------------------------------------------
	// Command outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmdValid <= 1'b0;
			cmdSrc <= access_arbiter_pkg::SRC_NONE;
			cmdOut <= '0;
			cmdRefused <= 1'b0;
		end else begin
			cmdValid <= anyGrant;
			cmdSrc <= grantSrc;
			cmdOut <= anyGrant ? grantCmd : cmdOut;
			cmdRefused <= refusedAny;
		end
	end

	// ------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			exclusiveOwner <= access_arbiter_pkg::OWN_NONE;
			localMode <= 1'b0;
		end else begin
			exclusiveOwner <= owner_next;
			localMode <= activeLoaded_reg ? localActive_reg :
				(storedSel_reg == access_arbiter_pkg::SEL_LOCAL);
		end
	end

endmodule
`default_nettype wire

// File: src/input_sync.sv
/*
 * Three-stage synchroniser for a group of pin inputs.
 * The output follows only when the second and third stages agree.
 * Assumes the inputs are asynchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic ref_clk, // System clock
	input wire logic rst_n, // Asynchronous reset, low active
	input wire logic [WIDTH-1:0] pinIn, // Raw pin levels
	output logic [WIDTH-1:0] syncOut // Filtered levels
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					stage1_reg[i] <= INIT[i];
					stage2_reg[i] <= INIT[i];
					stage3_reg[i] <= INIT[i];
					syncOut[i] <= INIT[i];
				end else begin
					stage1_reg[i] <= pinIn[i];
					stage2_reg[i] <= stage1_reg[i];
					stage3_reg[i] <= stage2_reg[i];
					// Stage one is never looked at here
					if (stage2_reg[i] == stage3_reg[i]) begin
						syncOut[i] <= stage3_reg[i];
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire
